// ---- include/ctb_consts.vh ----
// Constants of the capture time-base block: offsets, fields, reset values
`ifndef CTB_CONSTS_VH
`define CTB_CONSTS_VH

// ****************************************
// Register byte offsets (wb_adr_i[7:0])
// ****************************************
`define CTB_OFS_CTR 8'h00
`define CTB_OFS_PHS 8'h04
`define CTB_OFS_CAPTURE_SLOT_ONE 8'h08
`define CTB_OFS_CAPTURE_SLOT_TWO 8'h0c
`define CTB_OFS_CAPTURE_SLOT_THREE 8'h10
`define CTB_OFS_CAPTURE_SLOT_FOUR 8'h14
`define CTB_OFS_CTL1 8'h18
`define CTB_OFS_CTL2 8'h1c
`define CTB_OFS_STAT 8'h20

// ****************************************
// First control register fields
// ****************************************
`define CTB_C1_FREE 15
`define CTB_C1_SOFT 14
`define CTB_C1_PS_HI 13
`define CTB_C1_PS_LO 9
`define CTB_C1_LDEN 8

// ****************************************
// Second control register fields
// ****************************************
`define CTB_C2_ONESHOT 0
`define CTB_C2_STOP_HI 2
`define CTB_C2_STOP_LO 1
`define CTB_C2_REARM 3
`define CTB_C2_SYNCEN 5
`define CTB_C2_SWSYNC 8
`define CTB_C2_MODE 9

// ****************************************
// Reset values
// ****************************************
`define CTB_RST_WORD 32'h0000_0000
`define CTB_RST_CTL1 16'h0000
`define CTB_RST_STOP 2'h0
`define CTB_RST_SEQ 2'h0
`define CTB_RST_PS 5'h00

`endif

// ---- hw/ctb_core.v ----
// Capture time-base core: counter, phase preload, capture slots, control
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ctb_consts.vh"


module ctb_core (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg wb_ack_o,
	output reg [31:0] wb_dat_o,
	input wire cap_pin_i,
	input wire sync_in_i,
	input wire emu_suspend_i,
	output reg pin_o,
	output reg pin_oe_n_o
);

	// ****************************************
	// State
	// ****************************************
	reg [31:0] time_stamp_counter;
	reg [31:0] phase_preload;
	reg [31:0] cap [0:3];
	reg [15:0] ctl1;
	reg one_shot;
	reg [1:0] stop_value;
	reg sync_in_enable;
	reg mode_select;
	reg [1:0] event_sequencer;
	reg stopped;
	reg pin_prev;
	reg [4:0] pre_cnt;
	reg pre_tog;
	reg pre_sig;
	reg pre_prev;
	reg [31:0] rd_mux;

	// ****************************************
	// Byte-lane merge of write data
	// ****************************************

	// Keeps old bytes whose select line is low
	function [31:0] ctb_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] sel;
		integer b;
		begin
			ctb_merge = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					ctb_merge[8*b +: 8] = new_v[8*b +: 8];
				end
			end
		end
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************

	// Writes take effect at the edge where the master sees ack
	wire req = wb_cyc_i & wb_stb_i;
	wire wr = req & wb_we_i & wb_ack_o;
	wire wr_ctr = wr & (wb_adr_i == `CTB_OFS_CTR);
	wire wr_phs = wr & (wb_adr_i == `CTB_OFS_PHS);
	wire wr_ctl1 = wr & (wb_adr_i == `CTB_OFS_CTL1);
	wire wr_ctl2 = wr & (wb_adr_i == `CTB_OFS_CTL2);
	wire [3:0] wr_cap;
	assign wr_cap[0] = wr & (wb_adr_i == `CTB_OFS_CAPTURE_SLOT_ONE);
	assign wr_cap[1] = wr & (wb_adr_i == `CTB_OFS_CAPTURE_SLOT_TWO);
	assign wr_cap[2] = wr & (wb_adr_i == `CTB_OFS_CAPTURE_SLOT_THREE);
	assign wr_cap[3] = wr & (wb_adr_i == `CTB_OFS_CAPTURE_SLOT_FOUR);
	wire [31:0] wdat = ctb_merge(rd_mux, wb_dat_i, wb_sel_i);
	wire rearm = wr_ctl2 & wdat[`CTB_C2_REARM];
	wire sw_sync = wr_ctl2 & wdat[`CTB_C2_SWSYNC];

	// Ack one cycle after the request, dropped the cycle after
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always @* begin
		case (wb_adr_i)
			`CTB_OFS_CTR: rd_mux = time_stamp_counter;
			`CTB_OFS_PHS: rd_mux = phase_preload;
			`CTB_OFS_CAPTURE_SLOT_ONE: rd_mux = cap[0];
			`CTB_OFS_CAPTURE_SLOT_TWO: rd_mux = cap[1];
			`CTB_OFS_CAPTURE_SLOT_THREE: rd_mux = cap[2];
			`CTB_OFS_CAPTURE_SLOT_FOUR: rd_mux = cap[3];
			`CTB_OFS_CTL1: rd_mux = {16'h0000, ctl1};
			`CTB_OFS_CTL2: rd_mux = {22'h000000, mode_select, 3'h0, sync_in_enable,
				2'h0, stop_value, one_shot};
			`CTB_OFS_STAT: rd_mux = {29'h00000000, stopped, event_sequencer};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data latched with the ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= `CTB_RST_WORD;
		end else if (req & ~wb_ack_o) begin
			wb_dat_o <= rd_mux;
		end
	end

	// ****************************************
	// Event prescaler
	// ****************************************
	wire [4:0] prescale = ctl1[`CTB_C1_PS_HI:`CTB_C1_PS_LO];
	wire pin_rise = cap_pin_i & ~pin_prev;

	// Toggle every k input rises gives one output period per 2k rises
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_prev <= 1'b0;
			pre_cnt <= `CTB_RST_PS;
			pre_tog <= 1'b0;
			pre_sig <= 1'b0;
			pre_prev <= 1'b0;
		end else begin
			pin_prev <= cap_pin_i;
			pre_prev <= pre_sig;
			if (prescale == 5'h00) begin
				pre_cnt <= `CTB_RST_PS;
				pre_tog <= 1'b0;
				pre_sig <= cap_pin_i;
			end else begin
				pre_sig <= pre_tog;
				if (pin_rise) begin
					if (pre_cnt == prescale - 5'h01) begin
						pre_cnt <= `CTB_RST_PS;
						pre_tog <= ~pre_tog;
					end else begin
						pre_cnt <= pre_cnt + 5'h01;
					end
				end
			end
		end
	end

	// ****************************************
	// Edge qualification and event decode
	// ****************************************
	wire rise = pre_sig & ~pre_prev;
	wire fall = ~pre_sig & pre_prev;
	wire edge_pol = ctl1[{event_sequencer, 1'b0}];
	wire edge_hit = edge_pol ? fall : rise;
	wire evt = edge_hit & ~mode_select & ~stopped;
	wire load = evt & ctl1[`CTB_C1_LDEN];
	wire evt_reset = evt & ctl1[{event_sequencer, 1'b1}];
	wire stop_hit = evt & one_shot & (event_sequencer == stop_value);
	wire prd_hit = mode_select & (time_stamp_counter == cap[0]);

	// Sequencer walks the slots; one-shot stop freezes it until rearm
	always @(posedge clk_i) begin
		if (rst_i) begin
			event_sequencer <= `CTB_RST_SEQ;
			stopped <= 1'b0;
		end else if (rearm) begin
			event_sequencer <= `CTB_RST_SEQ;
			stopped <= stop_hit; // a stop in the same cycle still wins
		end else if (stop_hit) begin
			stopped <= 1'b1;
		end else if (evt) begin
			event_sequencer <= event_sequencer + 2'h1;
		end
	end

	// ****************************************
	// Time-base counter
	// ****************************************
	wire ctr_zero = (time_stamp_counter == 32'h0000_0000);
	wire ctr_run = ~emu_suspend_i | ctl1[`CTB_C1_FREE] |
		(ctl1[`CTB_C1_SOFT] & ~ctr_zero);
	wire do_sync = (sync_in_i & sync_in_enable) | sw_sync;

	// Sync beats software write, which beats clears and counting
	always @(posedge clk_i) begin
		if (rst_i) begin
			time_stamp_counter <= `CTB_RST_WORD;
		end else if (do_sync) begin
			time_stamp_counter <= phase_preload;
		end else if (wr_ctr) begin
			time_stamp_counter <= wdat;
		end else if (evt_reset | prd_hit) begin
			time_stamp_counter <= 32'h0000_0000;
		end else if (ctr_run) begin
			time_stamp_counter <= time_stamp_counter + 32'h0000_0001;
		end
	end

	// Phase preload register
	always @(posedge clk_i) begin
		if (rst_i) begin
			phase_preload <= `CTB_RST_WORD;
		end else if (wr_phs) begin
			phase_preload <= wdat;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************

	// Software write wins over the one-shot auto clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctl1 <= `CTB_RST_CTL1;
		end else if (wr_ctl1) begin
			ctl1 <= wdat[15:0];
		end else if (stop_hit) begin
			ctl1[`CTB_C1_LDEN] <= 1'b0;
		end
	end

	// Second control word; rearm and forced sync are strobes only
	always @(posedge clk_i) begin
		if (rst_i) begin
			one_shot <= 1'b0;
			stop_value <= `CTB_RST_STOP;
			sync_in_enable <= 1'b0;
			mode_select <= 1'b0;
		end else if (wr_ctl2) begin
			one_shot <= wdat[`CTB_C2_ONESHOT];
			stop_value <= wdat[`CTB_C2_STOP_HI:`CTB_C2_STOP_LO];
			sync_in_enable <= wdat[`CTB_C2_SYNCEN];
			mode_select <= wdat[`CTB_C2_MODE];
		end
	end

	// ****************************************
	// Capture slots
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_slot
			wire hit = load & (event_sequencer == i);
			if (i < 2) begin : g_active
				// Active slot: stamp, software, or shadow at period
				always @(posedge clk_i) begin
					if (rst_i) begin
						cap[i] <= `CTB_RST_WORD;
					end else if (hit) begin
						cap[i] <= time_stamp_counter;
					end else if (wr_cap[i]) begin
						cap[i] <= wdat;
					end else if (prd_hit) begin
						cap[i] <= cap[i + 2];
					end
				end
			end else begin : g_shadow
				// Shadow slot: stamp, own write, or mirrored active write
				always @(posedge clk_i) begin
					if (rst_i) begin
						cap[i] <= `CTB_RST_WORD;
					end else if (hit) begin
						cap[i] <= time_stamp_counter;
					end else if (wr_cap[i]) begin
						cap[i] <= wdat;
					end else if (mode_select & wr_cap[i - 2]) begin
						cap[i] <= wdat;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Shared pin
	// ****************************************

	// Driven only in PWM mode; high while counter below compare
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
			pin_oe_n_o <= 1'b1;
		end else begin
			pin_oe_n_o <= ~mode_select;
			pin_o <= mode_select & (time_stamp_counter < cap[1]);
		end
	end

endmodule // ctb_core

// ---- tb/ctb_core_props.sv ----
// Concurrent checks on the capture time-base core ports
`timescale 1ns/1ps
module ctb_core_props (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	input wire cap_pin_i,
	input wire sync_in_i,
	input wire emu_suspend_i,
	input wire pin_o,
	input wire pin_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers: one cycle late, one cycle long, never unasked
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	// Pin stays quiet in capture mode and turns only after a mode write
	a_pin_quiet: assert property (pin_oe_n_o |-> !pin_o) else $error("pin driven in capture mode");
	a_mode_to_pin: assert property ($changed(pin_oe_n_o) |->
		$past(wb_we_i && wb_adr_i == 8'h1c, 1) || $past(wb_we_i && wb_adr_i == 8'h1c, 2))
		else $error("pin enable changed without mode write");
	// Read widths of narrow and missing registers; outputs after reset
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h24 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_ctl1_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o[31:16] == 16'h0)
		else $error("control upper half not zero");
	a_status_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o[31:3] == 29'h0)
		else $error("status upper bits not zero");
	a_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && pin_oe_n_o && wb_dat_o == 32'h0)
		else $error("outputs not cleared by reset");
endmodule // ctb_core_props

bind ctb_core ctb_core_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o, .wb_dat_o, .cap_pin_i, .sync_in_i, .emu_suspend_i, .pin_o, .pin_oe_n_o);

// ---- tb/ctb_pin_model.sv ----
// Pulse train source that drives the capture input
`timescale 1ns/1ps
module ctb_pin_model #(parameter int HALF = 3) (
	input wire clk_i,
	input wire run_i,
	output logic pin_o
);
	int cnt = 0;
	initial pin_o = 1'b0;
	// Toggle every HALF cycles while running; whole pulses end low
	always @(posedge clk_i)
		if (run_i) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				pin_o <= ~pin_o;
		end
endmodule // ctb_pin_model

// ---- tb/testbench.sv ----
// Self-checking bench for the capture time-base core
`timescale 1ns/1ps
module testbench;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic sync_in_i = 0, emu_suspend_i = 0, run = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, v, e, m;
	logic [31:0] exp_q[$], msk_q[$];
	wire wb_ack_o, cap_pin_i, pin_o, pin_oe_n_o;
	wire [31:0] wb_dat_o;
	int seed = 32'h74d9, fails = 0, check_count = 0;
	always #2.5 clk_i = ~clk_i;
	ctb_core u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_ack_o, .wb_dat_o, .cap_pin_i, .sync_in_i, .emu_suspend_i, .pin_o, .pin_oe_n_o);
	ctb_pin_model u_pin (.clk_i, .run_i(run), .pin_o(cap_pin_i));
	// Compare each read answer with the oldest noted expectation
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			check_count++;
			if ((wb_dat_o & m) !== e) begin
				fails++;
				$display("Error read %h expected %h seen %h", wb_adr_i, e, wb_dat_o & m);
			end
		end
	// One classic bus cycle, held until ack is sampled
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			fails++;
			$display("Error bus ack expected 1 seen %b", wb_ack_o);
		end
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mk);
		exp_q.push_back(ev & mk);
		msk_q.push_back(mk);
		xfer(1'b0, a, 32'h0);
	endtask
	// Direct level check of a settled output
	task automatic chk(input string what, input logic [31:0] ev, input logic [31:0] sv);
		check_count++;
		if (sv !== ev) begin
			fails++;
			$display("Error %s expected %h seen %h", what, ev, sv);
		end
	endtask
	// One whole input pulse, then time for the stamp to land
	task automatic pulse;
		run <= 1'b1;
		repeat (6) @(posedge clk_i);
		run <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic wrap_up;
		$display("Checks %0d, errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 4; a <= 36; a += 4)
			rd(a[7:0], 32'h0, '1);
		for (int i = 1; i <= 6; i++) begin
			v = $random(seed);
			wr(8'(4 * i), v);
			rd(8'(4 * i), v, (i == 6) ? 32'hffff : '1);
		end
		emu_suspend_i <= 1'b1;
		wr(8'h18, 32'h0);
		v = $random(seed);
		wr(8'h00, v);
		rd(8'h00, v, '1);
		wr(8'h00, 32'hfffffff8);
		wr(8'h18, 32'h4000);
		repeat (12) @(posedge clk_i);
		rd(8'h00, 32'h0, '1);
		wr(8'h04, v);
		wr(8'h18, 32'h0);
		wr(8'h1c, 32'h100);
		rd(8'h00, v, '1);
		rd(8'h1c, 32'h0, 32'h100);
		wr(8'h1c, 32'h20);
		wr(8'h00, 32'h0);
		sync_in_i <= 1'b1;
		@(posedge clk_i);
		sync_in_i <= 1'b0;
		rd(8'h00, v, '1);
		wr(8'h18, 32'h1c4);
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 32'h100 + k);
			pulse();
		end
		for (int k = 0; k < 4; k++)
			rd(8'(8 + 4 * k), 32'h102 + (k >> 1), '1);
		rd(8'h00, 32'h0, '1);
		chk("pin enable", 32'h1, {31'h0, pin_oe_n_o});
		wr(8'h18, 32'h500);
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, 32'h300 + k);
			pulse();
		end
		rd(8'h08, 32'h301, '1);
		wr(8'h1c, 32'hb);
		wr(8'h18, 32'h100);
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, 32'h200 + k);
			pulse();
		end
		rd(8'h08, 32'h200, '1);
		rd(8'h0c, 32'h201, '1);
		rd(8'h10, 32'h103, '1);
		rd(8'h18, 32'h0, 32'h100);
		rd(8'h20, 32'h5, 32'h7);
		wr(8'h1c, 32'h8);
		wr(8'h00, 32'h400);
		pulse();
		rd(8'h08, 32'h200, '1);
		rd(8'h20, 32'h1, 32'h7);
		wr(8'h1c, 32'h200);
		wr(8'h08, 32'h80);
		wr(8'h0c, 32'h33);
		wr(8'h14, 32'h44);
		rd(8'h10, 32'h80, '1);
		rd(8'h0c, 32'h33, '1);
		wr(8'h00, 32'h80);
		rd(8'h0c, 32'h44, '1);
		rd(8'h00, 32'h0, '1);
		wr(8'h18, 32'h100);
		pulse();
		rd(8'h0c, 32'h44, '1);
		chk("pin enable", 32'h0, {31'h0, pin_oe_n_o});
		chk("pin level", 32'h1, {31'h0, pin_o});
		wrap_up();
	end
endmodule // testbench
